/* File: hw/mmpd_top.v */
// memory map control: page index, bus steering and select decode
`timescale 1ns/1ps
module mmpd_top #(
    parameter       WRITE_SPECIAL_ONLY = 0,
    parameter [1:0] PARTITION_SWITCHES = 2'b00
) (
    // clock and reset
    input  wire        i_ref_clk,
    input  wire        i_sys_rst,
    // cpu side
    input  wire [15:0] i_cpu_addr,
    input  wire [15:0] i_cpu_wdata,
    input  wire        i_cpu_valid,
    input  wire        i_cpu_write,
    input  wire        i_cpu_swap,
    // far call / return dedicated page path
    input  wire        i_far_wr,
    input  wire [5:0]  i_far_page,
    // mode and mapping controls
    input  wire [2:0]  i_mode,
    input  wire        i_port_e_external_enable,
    input  wire        i_port_k_expansion_enable,
    input  wire        i_rom_enable,
    input  wire [15:0] i_reg_base,
    input  wire [15:0] i_ram_base,
    input  wire [15:0] i_ram_mask,
    input  wire [15:0] i_eep_base,
    input  wire [15:0] i_eep_mask,
    input  wire        i_eep_enable,
    input  wire        i_dbg_active,
    input  wire [10:0] i_reg_impl_top,
    // read data sources
    input  wire [15:0] i_reg_rdata,
    input  wire [15:0] i_dbg_rdata,
    input  wire [15:0] i_ram_rdata,
    input  wire [15:0] i_eep_rdata,
    input  wire [15:0] i_rom_rdata,
    input  wire [15:0] i_ext_rdata,
    // outputs to the cpu
    output reg  [15:0] o_cpu_rdata,
    output reg  [5:0]  o_far_page,
    // outgoing core buses
    output reg  [15:0] o_core_addr,
    output reg  [15:0] o_core_wdata,
    output reg         o_core_write,
    // block select, one-hot, and program page select
    output reg  [5:0]  o_block_sel,
    output reg  [7:0]  o_program_page_select,
    // port K pins
    output reg  [5:0]  o_extended_page_address,
    output reg         o_emulation_chip_select_n,
    output reg         o_external_chip_select_n,
    output reg         o_port_k_hi_is_select
);
`include "mmpd_defines.vh"

    localparam integer PGW = `MMPD_PG_W;
    // reset value is paired with the write variant chosen at integration
    localparam [7:0] RST_VAL = (WRITE_SPECIAL_ONLY != 0) ?
                               `MMPD_RST_SPECIAL : `MMPD_RST_ANY;

    reg  [5:0]  page_index_bits_reg;
    reg  [5:0]  page_index_bits_next;
    reg  [5:0]  bus_pend_reg;
    reg         bus_pend_valid_reg;
    wire [15:0] rd_mux;
    reg  [5:0]  sel;
    reg         in_win;
    reg         win_internal;
    reg  [9:0]  reg_off;
    reg         in_reg_blk;
    reg         reg_removed;
    reg         reg_unimpl;
    reg         emu_cs;
    reg         ext_cs;
    reg  [5:0]  xab;
    wire        page_off_hit;

    // range test used by the register, ram and eeprom decode branches
    function in_range;
        input [15:0] a;
        input [15:0] base;
        input [15:0] mask;
        begin
            in_range = ((a & mask) == (base & mask));
        end
    endfunction

    // mode class helpers
    function is_expanded;
        input [2:0] m;
        begin
            is_expanded = (m == `MMPD_MODE_ES) || (m == `MMPD_MODE_EX) ||
                          (m == `MMPD_MODE_EN) || (m == `MMPD_MODE_NX);
        end
    endfunction

    function is_emulation;
        input [2:0] m;
        begin
            is_emulation = (m == `MMPD_MODE_EX) || (m == `MMPD_MODE_EN);
        end
    endfunction

    function is_special;
        input [2:0] m;
        begin
            is_special = ~m[2];
        end
    endfunction

    // first page index that is on chip for each partition
    function [5:0] first_internal;
        input [1:0] sw;
        begin
            case (sw)
                2'b00:   first_internal = 6'h38;
                2'b01:   first_internal = 6'h30;
                2'b10:   first_internal = 6'h20;
                default: first_internal = 6'h00;
            endcase
        end
    endfunction

    // page window is on chip only at or above the partition split
    function page_internal;
        input [5:0] pg;
        input [1:0] sw;
        begin
            page_internal = (sw == 2'b11) || (pg >= first_internal(sw));
        end
    endfunction

    // register block offset decode; block is 1K aligned, so the
    // low address bits already are the offset
    always @* begin
        in_reg_blk = in_range(i_cpu_addr, i_reg_base, 16'hFC00);
        reg_off    = i_cpu_addr[9:0];
        reg_removed = 1'b0;
        if (is_expanded(i_mode) &&
            (reg_off <= `MMPD_OFF_DDRB)) begin
            reg_removed = 1'b1;
        end
        if (is_expanded(i_mode) && i_port_e_external_enable &&
            ((reg_off == `MMPD_OFF_PORTE) ||
             (reg_off == `MMPD_OFF_DDRE))) begin
            reg_removed = 1'b1;
        end
        if ((i_mode == `MMPD_MODE_SP) &&
            (reg_off <= `MMPD_OFF_EXP_END)) begin
            reg_removed = 1'b1;
        end
        if (is_emulation(i_mode) && i_port_k_expansion_enable &&
            ((reg_off == `MMPD_OFF_PORTK) ||
             (reg_off == `MMPD_OFF_DDRK))) begin
            reg_removed = 1'b1;
        end
        // offsets past the top of the implemented range are holes
        reg_unimpl = ({1'b0, reg_off} > i_reg_impl_top);
    end

    // page index location; shared by the write stage and read-back
    assign page_off_hit = in_reg_blk && (reg_off == `MMPD_OFF_PAGE);

    // prioritised one-hot select
    always @* begin
        // window bounds are inclusive at both ends
        in_win = (i_cpu_addr >= `MMPD_WIN_LO) &&
                 (i_cpu_addr <= `MMPD_WIN_HI);
        win_internal = page_internal(page_index_bits_reg,
                                     PARTITION_SWITCHES);
        // idle cycles select nothing, so no chip select can glitch out
        sel = `MMPD_SEL_NONE;
        if (!i_cpu_valid) begin
            sel = `MMPD_SEL_NONE;
        end else if (i_dbg_active) begin
            sel = `MMPD_SEL_DBG;
        end else if (in_reg_blk && !reg_removed && !reg_unimpl) begin
            sel = `MMPD_SEL_REG;
        end else if (in_reg_blk && !reg_removed) begin
            sel = `MMPD_SEL_NONE;
        end else if (in_reg_blk) begin
            // removed or missing registers stay dark instead of letting
            // ram or the external bus show through the hole
            sel = `MMPD_SEL_NONE;
        end else if (in_range(i_cpu_addr, i_ram_base, i_ram_mask)) begin
            sel = `MMPD_SEL_RAM;
        end else if (i_eep_enable &&
                     in_range(i_cpu_addr, i_eep_base, i_eep_mask)) begin
            sel = `MMPD_SEL_EEP;
        end else if (i_rom_enable && i_cpu_addr[15:14] != 2'b00 &&
                     (!in_win || win_internal)) begin
            sel = `MMPD_SEL_ROM;
        end else if (is_expanded(i_mode)) begin
            sel = `MMPD_SEL_EXT;
        end
    end

    // port K chip selects; external select only covers claimed space
    // because removed and unimplemented holes decode to no select
    always @* begin
        emu_cs = i_port_k_expansion_enable && is_emulation(i_mode) &&
                 (sel == `MMPD_SEL_ROM);
        ext_cs = i_port_k_expansion_enable && !emu_cs &&
                 (sel == `MMPD_SEL_EXT);
    end

    // extended address: page bits inside the window, fixed codes outside
    always @* begin
        if (in_win) begin
            xab = page_index_bits_reg;
        end else if (i_cpu_addr[15:14] == 2'b00) begin
            xab = `MMPD_XAB_LOW;
        end else if (i_cpu_addr[15:14] == 2'b01) begin
            xab = `MMPD_XAB_MID;
        end else begin
            xab = `MMPD_XAB_TOP;
        end
    end

    // page index next value; far path wins over a staged bus write so
    // the instruction leaves with its own page in place
    always @* begin
        page_index_bits_next = page_index_bits_reg;
        if (bus_pend_valid_reg) begin
            page_index_bits_next = bus_pend_reg;
        end
        if (i_far_wr) begin
            page_index_bits_next = i_far_page;
        end
    end

    // bus write staged one cycle before it applies
    // wdata is captured every cycle; only the valid flag gates it
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_pend_reg       <= 6'h00;
            bus_pend_valid_reg <= 1'b0;
        end else begin
            bus_pend_reg       <= i_cpu_wdata[PGW-1:0];
            bus_pend_valid_reg <= i_cpu_valid && i_cpu_write &&
                page_off_hit &&
                (!WRITE_SPECIAL_ONLY || is_special(i_mode));
        end
    end

    // index register; reset value tied to write variant
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            page_index_bits_reg <= RST_VAL[5:0];
        end else begin
            page_index_bits_reg <= page_index_bits_next;
        end
    end

    // read steering; the swap is applied after the source is picked
    mmpd_read_mux u_read_mux (
        .i_sel      (sel),
        .i_swap     (i_cpu_swap),
        .i_reg_data (i_reg_rdata),
        .i_dbg_data (i_dbg_rdata),
        .i_ram_data (i_ram_rdata),
        .i_eep_data (i_eep_rdata),
        .i_rom_data (i_rom_rdata),
        .i_ext_data (i_ext_rdata),
        .o_data     (rd_mux)
    );

    // registered outputs; register read of page index overlays
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cpu_rdata               <= 16'h0000;
            o_far_page                <= RST_VAL[5:0];
            o_core_addr               <= 16'h0000;
            o_core_wdata              <= 16'h0000;
            o_core_write              <= 1'b0;
            o_block_sel               <= `MMPD_SEL_NONE;
            o_program_page_select     <= {2'b00, RST_VAL[5:0]};
            o_extended_page_address   <= 6'h00;
            o_emulation_chip_select_n <= 1'b1;
            o_external_chip_select_n  <= 1'b1;
            o_port_k_hi_is_select     <= 1'b0;
        end else begin
            // page index has no read source of its own, so overlay it
            if ((sel == `MMPD_SEL_REG) && page_off_hit) begin
                o_cpu_rdata <= {10'h000, page_index_bits_reg};
            end else begin
                o_cpu_rdata <= rd_mux;
            end
            o_far_page              <= page_index_bits_next;
            o_core_addr             <= i_cpu_addr;
            o_core_wdata            <= i_cpu_wdata;
            o_core_write            <= i_cpu_valid & i_cpu_write;
            o_block_sel             <= sel;
            o_program_page_select   <= {2'b00, page_index_bits_next};
            o_extended_page_address <= xab;
            o_emulation_chip_select_n <= ~emu_cs;
            o_external_chip_select_n  <= ~ext_cs;
            o_port_k_hi_is_select   <= i_port_k_expansion_enable;
        end
    end
endmodule // mmpd_top

/* File: hw/mmpd_defines.vh */
// constants for the memory map page decoder
// Functional notes
// - page index reset/write variant chosen at integration
// - index maps 16K page into 0x8000-0xBFFF
// - index is unsigned page number 0..63
// - far call/return access index directly
// - bus write to index applies next cycle
// - far path update done before instruction ends
// - steer data buses, route outputs, swap bytes
// - decode address by mode and mapping registers
// - only one block select active at once
// - priority debug, regs, ram, eeprom, rom, external
// - expansion window lowest priority
// - expanded modes drop ports A and B
// - port E dropped in expanded modes when its enable set
// - special peripheral mode drops sixteen expansion regs
// - emulation with port K enable drops port K
// - port K bit 7 is emulation select low
// - port K bit 6 is external select low
// - removed or unimplemented space never selects external
// - window accesses drive page bits on extended address
// - window internal or external by partition switches
`ifndef MMPD_DEFINES_VH
`define MMPD_DEFINES_VH
`define MMPD_RST_ANY        8'h00
`define MMPD_RST_SPECIAL    8'h3C
`define MMPD_WIN_LO         16'h8000
`define MMPD_WIN_HI         16'hBFFF
`define MMPD_PG_W           6
// operating modes, mode input encoding
`define MMPD_MODE_SS        3'h0
`define MMPD_MODE_ES        3'h1
`define MMPD_MODE_ST        3'h2
`define MMPD_MODE_EX        3'h3
`define MMPD_MODE_SP        3'h4
`define MMPD_MODE_EN        3'h5
`define MMPD_MODE_NS        3'h6
`define MMPD_MODE_NX        3'h7
// register block offsets of port registers, expansion end and page index
`define MMPD_OFF_PORTA      10'h000
`define MMPD_OFF_PORTB      10'h001
`define MMPD_OFF_DDRA       10'h002
`define MMPD_OFF_DDRB       10'h003
`define MMPD_OFF_PORTE      10'h008
`define MMPD_OFF_DDRE       10'h009
`define MMPD_OFF_EXP_END    10'h00F
`define MMPD_OFF_PORTK      10'h032
`define MMPD_OFF_DDRK       10'h033
`define MMPD_OFF_PAGE       10'h030
// constant extended address outside the window
`define MMPD_XAB_LOW        6'h3D
`define MMPD_XAB_MID        6'h3E
`define MMPD_XAB_TOP        6'h3F
// one-hot select encodings
`define MMPD_SEL_DBG        6'h01
`define MMPD_SEL_REG        6'h02
`define MMPD_SEL_RAM        6'h04
`define MMPD_SEL_EEP        6'h08
`define MMPD_SEL_ROM        6'h10
`define MMPD_SEL_EXT        6'h20
`define MMPD_SEL_NONE       6'h00
`endif

/* File: hw/mmpd_read_mux.v */
// read data steering and byte swap toward the cpu
`timescale 1ns/1ps
module mmpd_read_mux (
    // select and data sources
    input  wire [5:0]  i_sel,
    input  wire        i_swap,
    input  wire [15:0] i_reg_data,
    input  wire [15:0] i_dbg_data,
    input  wire [15:0] i_ram_data,
    input  wire [15:0] i_eep_data,
    input  wire [15:0] i_rom_data,
    input  wire [15:0] i_ext_data,
    // steered result
    output reg  [15:0] o_data
);
`include "mmpd_defines.vh"
    reg [15:0] raw;
    // one source per one-hot select; none gives zero
    always @* begin
        case (i_sel)
            `MMPD_SEL_DBG: raw = i_dbg_data;
            `MMPD_SEL_REG: raw = i_reg_data;
            `MMPD_SEL_RAM: raw = i_ram_data;
            `MMPD_SEL_EEP: raw = i_eep_data;
            `MMPD_SEL_ROM: raw = i_rom_data;
            `MMPD_SEL_EXT: raw = i_ext_data;
            default:       raw = 16'h0000;
        endcase
        o_data = i_swap ? {raw[7:0], raw[15:8]} : raw;
    end
endmodule // mmpd_read_mux

/* File: tb/mmpd_top_sva.sv */
// assertion checker for the memory map page decoder
`timescale 1ns/1ps
`include "mmpd_defines.vh"
module mmpd_top_sva (
    // clock, reset and watched inputs
    input wire        i_ref_clk,
    input wire        i_sys_rst,
    input wire [15:0] i_cpu_addr,
    input wire        i_cpu_valid,
    input wire        i_cpu_write,
    input wire        i_far_wr,
    input wire [5:0]  i_far_page,
    input wire [2:0]  i_mode,
    input wire        i_port_k_expansion_enable,
    input wire        i_dbg_active,
    // watched outputs
    input wire [5:0]  o_block_sel,
    input wire [7:0]  o_program_page_select,
    input wire [5:0]  o_extended_page_address,
    input wire        o_emulation_chip_select_n,
    input wire        o_external_chip_select_n,
    input wire        o_port_k_hi_is_select
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // window read, expanded mode, no page change racing it
    wire win = i_cpu_valid && !i_cpu_write && !i_far_wr && i_mode[0]
        && i_port_k_expansion_enable && i_cpu_addr[15:14] == 2'b10;

    a_sel_onehot: assert property ($onehot0(o_block_sel))
        else $error("more than one block select");
    a_page_upper: assert property (o_program_page_select[7:6] == 2'b00)
        else $error("page upper bits not zero");
    a_far_apply: assert property (i_far_wr |=>
        o_program_page_select[5:0] == $past(i_far_page))
        else $error("far page not applied");
    a_cs_exclusive: assert property (o_emulation_chip_select_n
        || o_external_chip_select_n) else $error("both selects low");
    a_xcs_ext_only: assert property (!o_external_chip_select_n |->
        o_block_sel == `MMPD_SEL_EXT) else $error("xcs without external");
    a_gpio_idle: assert property (!$past(i_sys_rst)
        && !$past(i_port_k_expansion_enable) |->
        o_emulation_chip_select_n && o_external_chip_select_n)
        else $error("select low while port k is gpio");
    a_hi_flag: assert property (!$past(i_sys_rst) |->
        o_port_k_hi_is_select == $past(i_port_k_expansion_enable))
        else $error("port k select flag wrong");
    a_window_xab: assert property (win && !$past(i_cpu_write) |=>
        o_extended_page_address == o_program_page_select[5:0])
        else $error("extended address not page index");
    a_dbg_first: assert property (i_cpu_valid && i_dbg_active |=>
        o_block_sel == `MMPD_SEL_DBG) else $error("debug not selected");

    c_far: cover property (i_far_wr);
    c_ecs: cover property (!o_emulation_chip_select_n);
    c_xcs: cover property (!o_external_chip_select_n);
endmodule // mmpd_top_sva

bind mmpd_top mmpd_top_sva i_mmpd_top_sva (.i_ref_clk, .i_sys_rst,
    .i_cpu_addr, .i_cpu_valid, .i_cpu_write, .i_far_wr, .i_far_page,
    .i_mode, .i_port_k_expansion_enable, .i_dbg_active, .o_block_sel,
    .o_program_page_select, .o_extended_page_address,
    .o_emulation_chip_select_n, .o_external_chip_select_n,
    .o_port_k_hi_is_select);

/* File: tb/mmpd_mem_model.sv */
// far side model: memories and external bus answering reads
`timescale 1ns/1ps
module mmpd_mem_model (
    // address on the bus
    input  wire [15:0] i_addr,
    // read data per source
    output wire [15:0] o_reg_rdata,
    output wire [15:0] o_dbg_rdata,
    output wire [15:0] o_ram_rdata,
    output wire [15:0] o_eep_rdata,
    output wire [15:0] o_rom_rdata,
    output wire [15:0] o_ext_rdata
);
    // each source marks its data so wrong steering shows up
    assign o_reg_rdata = i_addr ^ 16'h1111;
    assign o_dbg_rdata = i_addr ^ 16'h2222;
    assign o_ram_rdata = i_addr ^ 16'h3355;
    assign o_eep_rdata = i_addr ^ 16'h4444;
    assign o_rom_rdata = i_addr ^ 16'h5555;
    assign o_ext_rdata = i_addr ^ 16'h6666;
endmodule // mmpd_mem_model

/* File: tb/mmpd_top_tb.sv */
// testbench for the memory map page decoder
`timescale 1ns/1ps
`include "mmpd_defines.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
    bad_count = bad_count + 1; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module mmpd_top_tb;
    reg         i_ref_clk = 1'b0;
    reg         i_sys_rst = 1'b1;
    reg  [15:0] addr = 16'h0000;
    reg  [15:0] wdata = 16'h0000;
    reg         valid = 1'b0, wr = 1'b0, swap = 1'b0, far_wr = 1'b0;
    reg  [5:0]  far_page = 6'h00;
    reg  [2:0]  mode = 3'h6;
    reg         port_e_external_enable = 1'b0, port_k_expansion_enable = 1'b0, dbg = 1'b0, rom_en = 1'b1;
    reg         eep_en = 1'b1;
    reg  [10:0] impl_top = 11'h3FF;
    reg  [15:0] ram_base = 16'h0000, eep_base = 16'h0000;
    wire [15:0] d_reg, d_dbg, d_ram, d_eep, d_rom, d_ext, rdata;
    wire [15:0] c_addr, c_wdata;
    wire [5:0]  sel, fpage, xab;
    wire [7:0]  page;
    wire        c_wr, ecs_n, xcs_n, khi;
    integer     bad_count = 0, n_tests = 0;

    mmpd_top #(.WRITE_SPECIAL_ONLY(0), .PARTITION_SWITCHES(2'b00)) i_mmpd_top (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_cpu_addr(addr),
        .i_cpu_wdata(wdata), .i_cpu_valid(valid), .i_cpu_write(wr),
        .i_cpu_swap(swap), .i_far_wr(far_wr), .i_far_page(far_page),
        .i_mode(mode), .i_port_e_external_enable(port_e_external_enable),
        .i_port_k_expansion_enable(port_k_expansion_enable), .i_rom_enable(rom_en),
        .i_reg_base(16'h0000), .i_ram_base(ram_base), .i_ram_mask(16'hF000),
        .i_eep_base(eep_base), .i_eep_mask(16'hE000), .i_eep_enable(eep_en),
        .i_dbg_active(dbg), .i_reg_impl_top(impl_top), .i_reg_rdata(d_reg),
        .i_dbg_rdata(d_dbg), .i_ram_rdata(d_ram), .i_eep_rdata(d_eep),
        .i_rom_rdata(d_rom), .i_ext_rdata(d_ext), .o_cpu_rdata(rdata),
        .o_far_page(fpage), .o_core_addr(c_addr), .o_core_wdata(c_wdata),
        .o_core_write(c_wr), .o_block_sel(sel), .o_program_page_select(page),
        .o_extended_page_address(xab), .o_emulation_chip_select_n(ecs_n),
        .o_external_chip_select_n(xcs_n), .o_port_k_hi_is_select(khi));
    mmpd_mem_model i_mmpd_mem_model (.i_addr(addr), .o_reg_rdata(d_reg),
        .o_dbg_rdata(d_dbg), .o_ram_rdata(d_ram), .o_eep_rdata(d_eep),
        .o_rom_rdata(d_rom), .o_ext_rdata(d_ext));

    initial forever #50 i_ref_clk = ~i_ref_clk;

    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // one bus cycle, entered at a falling edge
    task acc(input [2:0] m, input [15:0] a, input w, input [15:0] d);
        begin
            mode = m; addr = a; wr = w; wdata = d; valid = 1'b1;
            @(negedge i_ref_clk);
            valid = 1'b0; wr = 1'b0;
        end
    endtask
    task dec(input [2:0] m, input [15:0] a, input [5:0] e);
        begin
            acc(m, a, 1'b0, 16'h0000);
            `CHK(sel, e)
        end
    endtask
    task farw(input [5:0] p);
        begin
            far_wr = 1'b1; far_page = p;
            @(negedge i_ref_clk);
            far_wr = 1'b0;
        end
    endtask

    // hang guard, far beyond the 52 cycles the run needs
    initial begin
        #(100 * 3000);
        bad_count = bad_count + 1;
        give_verdict;
    end

    initial begin
        repeat (10) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        `CHK(page, 8'h00)
        `CHK(ecs_n & xcs_n, 1'b1)
        acc(3'h6, 16'h0030, 1'b1, 16'h0025);
        `CHK(c_wdata, 16'h0025)
        `CHK(c_wr, 1'b1)
        `CHK(c_addr, 16'h0030)
        `CHK(khi, 1'b0)
        `CHK(page, 8'h00)
        repeat (2) @(negedge i_ref_clk);
        `CHK(page, 8'h25)
        acc(3'h6, 16'h0030, 1'b1, 16'hFFFF);
        repeat (2) @(negedge i_ref_clk);
        `CHK(page, 8'h3F)
        farw(6'h11);
        `CHK(page, 8'h11)
        `CHK(fpage, 6'h11)
        dec(3'h6, 16'h0030, `MMPD_SEL_REG);
        `CHK(rdata, 16'h0011)
        `CHK(c_wr, 1'b0)
        $display("page tests done");
        dec(3'h6, 16'h0010, `MMPD_SEL_REG);
        dec(3'h6, 16'h0800, `MMPD_SEL_RAM);
        `CHK(rdata, 16'h3B55)
        swap = 1'b1;
        dec(3'h6, 16'h0800, `MMPD_SEL_RAM);
        `CHK(rdata, 16'h553B)
        swap = 1'b0;
        dec(3'h6, 16'h1800, `MMPD_SEL_EEP);
        dec(3'h6, 16'hC000, `MMPD_SEL_ROM);
        dec(3'h7, 16'h3000, `MMPD_SEL_EXT);
        dec(3'h6, 16'h0000, `MMPD_SEL_REG);
        dec(3'h7, 16'h0000, `MMPD_SEL_NONE);
        dec(3'h7, 16'h0008, `MMPD_SEL_REG);
        port_e_external_enable = 1'b1;
        dec(3'h7, 16'h0008, `MMPD_SEL_NONE);
        dec(3'h4, 16'h000F, `MMPD_SEL_NONE);
        dec(3'h4, 16'h0010, `MMPD_SEL_REG);
        port_k_expansion_enable = 1'b1;
        dec(3'h5, 16'h0032, `MMPD_SEL_NONE);
        `CHK(khi, 1'b1)
        dec(3'h6, 16'h0032, `MMPD_SEL_REG);
        dbg = 1'b1;
        dec(3'h6, 16'h0800, `MMPD_SEL_DBG);
        dbg = 1'b0;
        ram_base = 16'h2000;
        eep_base = 16'h4000;
        dec(3'h6, 16'h2800, `MMPD_SEL_RAM);
        dec(3'h6, 16'h4000, `MMPD_SEL_EEP);
        ram_base = 16'h0000;
        eep_base = 16'h0000;
        $display("decode tests done");
        dec(3'h3, 16'hC000, `MMPD_SEL_ROM);
        `CHK({ecs_n, xcs_n}, 2'b01)
        dec(3'h3, 16'h3000, `MMPD_SEL_EXT);
        `CHK({ecs_n, xcs_n}, 2'b10)
        dec(3'h3, 16'h0000, `MMPD_SEL_NONE);
        `CHK(xcs_n, 1'b1)
        impl_top = 11'h020;
        dec(3'h3, 16'h0100, `MMPD_SEL_NONE);
        `CHK(xcs_n, 1'b1)
        impl_top = 11'h3FF;
        $display("select tests done");
        dec(3'h7, 16'h9000, `MMPD_SEL_EXT);
        `CHK(xab, 6'h11)
        dec(3'h7, 16'h0800, `MMPD_SEL_RAM);
        `CHK(xab, `MMPD_XAB_LOW)
        dec(3'h7, 16'h4000, `MMPD_SEL_ROM);
        `CHK(xab, `MMPD_XAB_MID)
        dec(3'h7, 16'hC000, `MMPD_SEL_ROM);
        `CHK(xab, `MMPD_XAB_TOP)
        farw(6'h37);
        dec(3'h7, 16'h9000, `MMPD_SEL_EXT);
        farw(6'h38);
        dec(3'h7, 16'h9000, `MMPD_SEL_ROM);
        `CHK(xab, 6'h38)
        rom_en = 1'b0;
        dec(3'h7, 16'hC000, `MMPD_SEL_EXT);
        rom_en = 1'b1;
        eep_en = 1'b0;
        dec(3'h7, 16'h1800, `MMPD_SEL_EXT);
        $display("window tests done");
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        `CHK(page, 8'h00)
        `CHK(fpage, 6'h00)
        i_sys_rst = 1'b0;
        farw(6'h05);
        `CHK(page, 8'h05)
        $display("reset tests done");
        give_verdict;
    end
endmodule // mmpd_top_tb
